//--- verilog/sbpi_pin_port.sv
// two-wire slave port and alert pin of the temperature sensor
// Operation
// - Command and write data are sampled from the data line on each clock rise.
// - Read data driven on the data line changes only on clock falls.
// - Data line is open-drain: pull low for zero, else release.
// - Alert goes active when temperature exceeds the high limit; in interrupt mode, dropping below the low limit also sets it.
// - A configuration bit selects interrupt or comparator alert mode.
// - Alert is active-low after reset; polarity bit makes it active-high.
// - Three address-select inputs form the low three slave address bits.
// - Address-select inputs are weakly pulled low; floating reads as zero.
// - Upper four address bits are a fixed, non-configurable device-type identifier.
// - Matching address byte is acknowledged; mismatch is not, and port idles.
module sbpi_pin_port
    import sbpi_pkg::*;
#(
    // arbitrary neutral value, not a real part's type code
    parameter logic [TYPE_BITS-1:0] DEVICE_TYPE_ID = 4'hA
) (
    // system clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // serial link
    input  wire logic                scl_clk,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe,
    // address straps
    input  wire logic [SEL_BITS-1:0] address_select_inputs,
    // alert pin
    output logic                     alert_out,
    output logic                     alert_oe,
    // configuration and measurement side
    input  wire sbpi_alert_cfg_type  alert_cfg,
    input  wire sbpi_temp_flags_type temp_flags,
    input  wire logic [BYTE_BITS-1:0] rd_data,
    output logic                     rd_done,
    output logic [BYTE_BITS-1:0]     wr_data,
    output logic                     wr_valid
);

    // ---------------- link domain ----------------
    logic                  link_rst;
    logic [SEL_BITS-1:0]   addr_sel;
    sbpi_link_state_type   state;
    sbpi_link_state_type   next_state;
    logic [2:0]            bit_cnt;
    logic [2:0]            next_bit_cnt;
    logic [BYTE_BITS-1:0]  rx_shift;
    logic [BYTE_BITS-1:0]  next_rx_shift;
    logic [BYTE_BITS-1:0]  tx_shift;
    logic [BYTE_BITS-1:0]  next_tx_shift;
    logic [BYTE_BITS-1:0]  wr_hold;
    logic [BYTE_BITS-1:0]  next_wr_hold;
    logic                  wr_tog;
    logic                  next_wr_tog;
    logic                  rd_tog;
    logic                  next_rd_tog;
    logic                  sda_rise;
    logic                  next_sda_rise;
    logic                  start_flag;
    logic                  next_start_flag;
    logic                  next_sda_oe;
    logic                  addr_hit;

    sbpi_sync #(.WIDTH(1)) u_sync_link_rst (
        .clk  (scl_clk),
        .rst  (1'b0),
        .din  (rst),
        .dout (link_rst)
    );

    // straps float low through the pad pull-down, logic sees a clean level
    sbpi_sync #(.WIDTH(SEL_BITS)) u_sync_addr (
        .clk  (scl_clk),
        .rst  (link_rst),
        .din  (address_select_inputs),
        .dout (addr_sel)
    );

    // rx_shift holds address bits 7..1 when the eighth bit arrives
    assign addr_hit = (rx_shift[6:0] == {DEVICE_TYPE_ID, addr_sel});
    assign sda_out  = PIN_LOW;

    // rising edge group: sampling and sequencing
    always_comb begin
        next_state    = state;
        next_bit_cnt  = bit_cnt;
        next_rx_shift = rx_shift;
        next_tx_shift = tx_shift;
        next_wr_hold  = wr_hold;
        next_wr_tog   = wr_tog;
        next_rd_tog   = rd_tog;
        next_sda_rise = sda_in;
        if (start_flag) begin
            next_state    = ST_ADDR;
            next_bit_cnt  = BIT_SECOND;
            next_rx_shift = {7'h00, sda_in};
        end else begin
            case (state)
                ST_ADDR: begin
                    next_rx_shift = {rx_shift[6:0], sda_in};
                    next_bit_cnt  = bit_cnt + 3'h1;
                    if (bit_cnt == BIT_LAST) begin
                        next_state = addr_hit ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    next_bit_cnt = BIT_FIRST;
                    if (rx_shift[0] == READ_BIT) begin
                        next_state    = ST_RD_DATA;
                        next_tx_shift = rd_data;
                    end else begin
                        next_state = ST_WR_DATA;
                    end
                end
                ST_WR_DATA: begin
                    next_rx_shift = {rx_shift[6:0], sda_in};
                    next_bit_cnt  = bit_cnt + 3'h1;
                    if (bit_cnt == BIT_LAST) begin
                        next_state   = ST_WR_ACK;
                        next_wr_hold = {rx_shift[6:0], sda_in};
                        next_wr_tog  = ~wr_tog;
                    end
                end
                ST_WR_ACK: begin
                    next_state   = ST_WR_DATA;
                    next_bit_cnt = BIT_FIRST;
                end
                ST_RD_DATA: begin
                    next_tx_shift = {tx_shift[6:0], 1'b0};
                    next_bit_cnt  = bit_cnt + 3'h1;
                    if (bit_cnt == BIT_LAST) begin
                        next_state  = ST_RD_ACK;
                        next_rd_tog = ~rd_tog;
                    end
                end
                ST_RD_ACK: begin
                    // master ack asks for another byte, nack ends the read
                    if (sda_in == PIN_LOW) begin
                        next_state    = ST_RD_DATA;
                        next_tx_shift = rd_data;
                        next_bit_cnt  = BIT_FIRST;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge scl_clk) begin
        if (link_rst) begin
            state    <= ST_IDLE;
            bit_cnt  <= BIT_FIRST;
            rx_shift <= BYTE_RESET;
            tx_shift <= BYTE_RESET;
            wr_hold  <= BYTE_RESET;
            wr_tog   <= 1'b0;
            rd_tog   <= 1'b0;
            sda_rise <= 1'b1;
        end else begin
            state    <= next_state;
            bit_cnt  <= next_bit_cnt;
            rx_shift <= next_rx_shift;
            tx_shift <= next_tx_shift;
            wr_hold  <= next_wr_hold;
            wr_tog   <= next_wr_tog;
            rd_tog   <= next_rd_tog;
            sda_rise <= next_sda_rise;
        end
    end

    // falling edge group: start detection and data line drive
    always_comb begin
        next_start_flag = sda_rise & ~sda_in;
        next_sda_oe     = 1'b0;
        if (!next_start_flag) begin
            case (state)
                ST_ADDR_ACK: next_sda_oe = 1'b1;
                ST_WR_ACK:   next_sda_oe = 1'b1;
                ST_RD_DATA:  next_sda_oe = ~tx_shift[7];
                default:     next_sda_oe = 1'b0;
            endcase
        end
    end

    always_ff @(negedge scl_clk) begin
        if (link_rst) begin
            start_flag <= 1'b0;
            sda_oe     <= 1'b0;
        end else begin
            start_flag <= next_start_flag;
            sda_oe     <= next_sda_oe;
        end
    end

    // ---------------- system domain ----------------
    logic               rd_tog_s;
    logic               wr_tog_s;
    logic               rd_tog_d;
    logic               wr_tog_d;
    logic               rd_event;
    logic               wr_event;
    logic               mode_q;
    logic               pol_q;
    logic               alert_active;
    logic               over_d;
    logic               under_d;
    logic               int_set;
    logic               next_alert_active;
    logic               next_alert_oe;
    logic [BYTE_BITS-1:0] next_wr_data;

    sbpi_sync #(.WIDTH(1)) u_sync_rd (
        .clk  (clk),
        .rst  (rst),
        .din  (rd_tog),
        .dout (rd_tog_s)
    );

    sbpi_sync #(.WIDTH(1)) u_sync_wr (
        .clk  (clk),
        .rst  (rst),
        .din  (wr_tog),
        .dout (wr_tog_s)
    );

    assign rd_event = rd_tog_s ^ rd_tog_d;
    assign wr_event = wr_tog_s ^ wr_tog_d;
    // interrupt mode latches on a fresh crossing of either limit
    assign int_set  = (temp_flags.over_high & ~over_d) | (temp_flags.under_low & ~under_d);

    always_comb begin
        next_wr_data = wr_data;
        if (wr_event) begin
            next_wr_data = wr_hold;
        end
        if (!mode_q) begin
            // comparator: hold active from over-high until under-low
            next_alert_active = alert_active;
            if (temp_flags.over_high) begin
                next_alert_active = 1'b1;
            end else if (temp_flags.under_low) begin
                next_alert_active = 1'b0;
            end
        end else begin
            // interrupt: sticky until a read completes, a new event wins
            next_alert_active = alert_active;
            if (int_set) begin
                next_alert_active = 1'b1;
            end else if (rd_event) begin
                next_alert_active = 1'b0;
            end
        end
        // pin level equals polarity when active; pull low whenever level is low
        next_alert_oe = ~(next_alert_active ~^ pol_q) ? 1'b1 : 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_tog_d     <= 1'b0;
            wr_tog_d     <= 1'b0;
            mode_q       <= MODE_RESET;
            pol_q        <= POL_RESET;
            alert_active <= 1'b0;
            over_d       <= 1'b0;
            under_d      <= 1'b0;
            alert_oe     <= 1'b0;
            rd_done      <= 1'b0;
            wr_valid     <= 1'b0;
            wr_data      <= BYTE_RESET;
        end else begin
            rd_tog_d     <= rd_tog_s;
            wr_tog_d     <= wr_tog_s;
            mode_q       <= alert_cfg.alert_mode_select_bit;
            pol_q        <= alert_cfg.alert_polarity_bit;
            alert_active <= next_alert_active;
            over_d       <= temp_flags.over_high;
            under_d      <= temp_flags.under_low;
            alert_oe     <= next_alert_oe;
            rd_done      <= rd_event;
            wr_valid     <= wr_event;
            wr_data      <= next_wr_data;
        end
    end

    assign alert_out = PIN_LOW;

    // ---------------- checks ----------------
    chk_addr_ack_match: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (state == ST_ADDR && bit_cnt == BIT_LAST && !start_flag && addr_hit)
        |=> (state == ST_ADDR_ACK && sda_oe))
        else $error("matching address not acknowledged");

    chk_addr_miss_idle: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (state == ST_ADDR && bit_cnt == BIT_LAST && !start_flag && !addr_hit)
        |=> (state == ST_IDLE) ##1 !sda_oe)
        else $error("mismatched address not left idle");

    chk_write_sample: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (state == ST_WR_DATA && !start_flag) |=> (rx_shift[0] == $past(sda_in)))
        else $error("write bit not sampled on clock rise");

    chk_read_bit_drive: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (state == ST_RD_DATA && !start_flag) |-> (sda_oe == ~tx_shift[7]))
        else $error("read bit not driven from shift register");

    chk_read_ack_release: assert property (
        @(posedge scl_clk) disable iff (link_rst)
        (state == ST_RD_ACK) |-> !sda_oe)
        else $error("data line held during master acknowledge");

    chk_wr_handover: assert property (
        @(posedge clk) disable iff (rst)
        $changed(wr_tog_s) |=> wr_valid ##1 !wr_valid)
        else $error("received byte not handed over once");

    chk_alert_reset_low: assert property (
        @(posedge clk)
        rst |=> (!pol_q && !alert_active && !alert_oe))
        else $error("alert not inactive low after reset");

    chk_alert_pin_level: assert property (
        @(posedge clk) disable iff (rst)
        (alert_active && !pol_q && $stable(alert_active) && $stable(pol_q)) |-> alert_oe)
        else $error("active-low alert not pulled low");

    chk_cmp_follow: assert property (
        @(posedge clk) disable iff (rst)
        (!mode_q && temp_flags.over_high)
        |=> alert_active ##1 (alert_oe == (alert_active != $past(pol_q))))
        else $error("comparator alert does not follow limit");

    chk_int_read_clear: assert property (
        @(posedge clk) disable iff (rst)
        (mode_q && rd_event && !int_set) |=> !alert_active)
        else $error("interrupt alert not cleared by read");

endmodule : sbpi_pin_port

//--- verilog/sbpi_pkg.sv
// package: constants, states and carriers of the sensor bus pin interface
package sbpi_pkg;

    localparam int       BYTE_BITS     = 8;
    localparam int       SEL_BITS      = 3;
    localparam int       TYPE_BITS     = 4;
    localparam int       SYNC_STAGES   = 2;
    localparam logic [2:0] BIT_FIRST   = 3'h0;
    localparam logic [2:0] BIT_SECOND  = 3'h1;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic     POL_RESET     = 1'h0;
    localparam logic     MODE_RESET    = 1'h0;
    localparam logic [7:0] BYTE_RESET  = 8'h00;
    localparam logic     READ_BIT      = 1'h1;
    localparam logic     PIN_LOW       = 1'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK
    } sbpi_link_state_type;

    // alert configuration bits as held by the configuration register
    typedef struct packed {
        logic alert_mode_select_bit;
        logic alert_polarity_bit;
    } sbpi_alert_cfg_type;

    // limit comparison results from the measurement engine
    typedef struct packed {
        logic over_high;
        logic under_low;
    } sbpi_temp_flags_type;

endpackage : sbpi_pkg

//--- verilog/sbpi_sync.sv
// two-flop level synchroniser
module sbpi_sync
    import sbpi_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset of the receiving domain
    input  wire logic             clk,
    input  wire logic             rst,
    // level in and synchronised level out
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end

endmodule : sbpi_sync

//--- test/sbpi_i2c_master_model.sv
// two-wire bus master model that drives the serial clock and the data line
module sbpi_i2c_master_model
    import sbpi_pkg::*;
(
    // serial clock, high outside frames except while idle pulses it
    output logic      scl_clk,
    // data line: request to pull low, and the resolved level
    output logic      sda_pull,
    input  wire logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;

    // a quarter of the 12 ns serial clock period
    localparam int Q = 3;

    initial begin
        scl_clk  = 1'b1;
        sda_pull = 1'b0;
    end

    // one serial clock period; data changes only while the clock is low
    task automatic tick(input logic pull, output logic got);
        scl_clk = 1'b0;
        #Q;
        sda_pull = pull;
        #Q;
        scl_clk = 1'b1;
        got = sda_line;
        #(2*Q);
    endtask : tick

    // clock pulses with the data line released
    task automatic idle(input int n);
        logic g;
        repeat (n) tick(1'b0, g);
    endtask : idle

    // a rise with data high, then data falls while the clock is high
    task automatic start();
        scl_clk = 1'b0;
        #Q;
        sda_pull = 1'b0;
        #Q;
        scl_clk = 1'b1;
        #Q;
        sda_pull = 1'b1;
        #Q;
    endtask : start

    // data rises while the clock is high; the clock then stands high
    task automatic stop();
        scl_clk = 1'b0;
        #Q;
        sda_pull = 1'b1;
        #Q;
        scl_clk = 1'b1;
        #Q;
        sda_pull = 1'b0;
        #Q;
    endtask : stop

    // eight bits out, most significant first, then the answer bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) tick(~b[i], g);
        tick(1'b0, ack);
    endtask : send_byte

    // eight bits in, then the master's own answer
    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            tick(1'b0, g);
            b[i] = g;
        end
        tick(~nack, g);
    endtask : recv_byte
endmodule : sbpi_i2c_master_model

//--- test/testbench.sv
// self-checking bench of the sensor bus pin interface
module testbench
    import sbpi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // arbitrary neutral type code
    localparam logic [TYPE_BITS-1:0] TYPE_ID = 4'hA;

    logic                clk;
    logic                rst;
    logic                scl_clk;
    logic                sda_pull;
    logic                sda_out;
    logic                sda_oe;
    logic                alert_out;
    logic                alert_oe;
    logic                rd_done;
    logic                wr_valid;
    logic [SEL_BITS-1:0] sel;
    sbpi_alert_cfg_type  cfg;
    sbpi_temp_flags_type flags;
    logic [7:0]          rd_data;
    logic [7:0]          wr_data;
    logic [7:0]          wr_last;
    int                  miscompares;
    int                  total_checks;
    int                  wr_cnt;
    int                  rd_cnt;
    logic                sda_line;
    logic                alert_line;

    // pull-ups on both open-drain lines
    assign sda_line   = ~((sda_oe & ~sda_out) | sda_pull);
    assign alert_line = ~(alert_oe & ~alert_out);

    sbpi_pin_port #(.DEVICE_TYPE_ID(TYPE_ID)) u_sbpi_pin_port (
        .clk(clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .address_select_inputs(sel),
        .alert_out(alert_out), .alert_oe(alert_oe), .alert_cfg(cfg),
        .temp_flags(flags), .rd_data(rd_data), .rd_done(rd_done),
        .wr_data(wr_data), .wr_valid(wr_valid)
    );

    sbpi_i2c_master_model u_sbpi_i2c_master_model (
        .scl_clk(scl_clk), .sda_pull(sda_pull), .sda_line(sda_line)
    );

    always #50 clk = ~clk;

    always @(negedge clk) begin
        if (wr_valid === 1'b1) begin
            wr_cnt++;
            wr_last = wr_data;
        end
        if (rd_done === 1'b1) rd_cnt++;
    end

    // the device may only move the data line while the serial clock is low
    always @(sda_oe) if (rst === 1'b0) chk({7'h00, scl_clk}, 8'h00);

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // waits a few cycles for the alert line to settle, then compares it
    task automatic chk_alert(input logic exp);
        for (int i = 0; i < 6 && alert_line !== exp; i++) @(negedge clk);
        chk({7'h00, alert_line}, {7'h00, exp});
    endtask : chk_alert

    task automatic read_frame(output logic [7:0] b);
        logic ack;
        u_sbpi_i2c_master_model.start();
        u_sbpi_i2c_master_model.send_byte({TYPE_ID, sel, READ_BIT}, ack);
        chk({7'h00, ack}, 8'h00);
        u_sbpi_i2c_master_model.recv_byte(1'b1, b);
        u_sbpi_i2c_master_model.stop();
    endtask : read_frame

    task automatic test_reset();
        fork
            u_sbpi_i2c_master_model.idle(20);
            cyc(16);
        join
        chk({6'h00, sda_oe, alert_oe}, 8'h00);
        chk({6'h00, sda_out, alert_out}, 8'h00);
        rst = 1'b0;
        cyc(3);
        chk({7'h00, alert_line}, 8'h01);
    endtask : test_reset

    task automatic test_write();
        logic       ack;
        int         n;
        logic [7:0] d;
        // select 0 stands for straps left floating
        for (int s = 0; s < 8; s++) begin
            cyc(1);
            sel = 3'(s);
            d = 8'h3C ^ 8'(s * 17);
            u_sbpi_i2c_master_model.idle(4);
            n = wr_cnt;
            u_sbpi_i2c_master_model.start();
            u_sbpi_i2c_master_model.send_byte({TYPE_ID, sel, 1'b0}, ack);
            chk({7'h00, ack}, 8'h00);
            u_sbpi_i2c_master_model.send_byte(d, ack);
            chk({7'h00, ack}, 8'h00);
            u_sbpi_i2c_master_model.stop();
            for (int i = 0; i < 10 && wr_cnt == n; i++) @(negedge clk);
            chk(wr_last, d);
            chk(8'(wr_cnt - n), 8'h01);
        end
    endtask : test_write

    task automatic test_mismatch();
        logic       ack;
        int         n;
        logic [7:0] bad [3];
        bad = '{{TYPE_ID ^ 4'h1, sel, 1'b0}, {TYPE_ID, sel ^ 3'h1, 1'b0}, 8'h00};
        n = wr_cnt;
        foreach (bad[i]) begin
            u_sbpi_i2c_master_model.start();
            u_sbpi_i2c_master_model.send_byte(bad[i], ack);
            chk({7'h00, ack}, 8'h01);
            u_sbpi_i2c_master_model.send_byte(8'h00, ack);
            chk({7'h00, ack}, 8'h01);
            u_sbpi_i2c_master_model.stop();
        end
        cyc(10);
        chk(8'(wr_cnt - n), 8'h00);
    endtask : test_mismatch

    task automatic test_read();
        logic [7:0] b;
        logic       ack;
        int         n;
        n = rd_cnt;
        read_frame(b);
        chk(b, 8'h96);
        cyc(1);
        rd_data = 8'h5A;
        // master ack asks for a second byte, reloaded from the same source
        u_sbpi_i2c_master_model.start();
        u_sbpi_i2c_master_model.send_byte({TYPE_ID, sel, READ_BIT}, ack);
        chk({7'h00, ack}, 8'h00);
        u_sbpi_i2c_master_model.recv_byte(1'b0, b);
        chk(b, 8'h5A);
        u_sbpi_i2c_master_model.recv_byte(1'b1, b);
        chk(b, 8'h5A);
        u_sbpi_i2c_master_model.stop();
        for (int i = 0; i < 10 && rd_cnt - n < 3; i++) @(negedge clk);
        chk(8'(rd_cnt - n), 8'h03);
    endtask : test_read

    task automatic test_alert_cmp();
        cyc(1);
        flags.over_high = 1'b1;
        chk_alert(1'b0);
        flags.over_high = 1'b0;
        cyc(4);
        chk({7'h00, alert_line}, 8'h00);
        flags.under_low = 1'b1;
        chk_alert(1'b1);
        flags.under_low = 1'b0;
        cfg.alert_polarity_bit = 1'b1;
        chk_alert(1'b0);
        flags.over_high = 1'b1;
        chk_alert(1'b1);
        flags.over_high = 1'b0;
        flags.under_low = 1'b1;
        chk_alert(1'b0);
        flags.under_low = 1'b0;
        cfg.alert_polarity_bit = 1'b0;
        chk_alert(1'b1);
    endtask : test_alert_cmp

    task automatic test_alert_int();
        logic [7:0] b;
        logic       ack;
        cfg.alert_mode_select_bit = 1'b1;
        cyc(3);
        flags.over_high = 1'b1;
        chk_alert(1'b0);
        flags.over_high = 1'b0;
        cyc(4);
        chk({7'h00, alert_line}, 8'h00);
        // host polls the alert response address, which is not this device's
        u_sbpi_i2c_master_model.start();
        u_sbpi_i2c_master_model.send_byte(8'h19, ack);
        chk({7'h00, ack}, 8'h01);
        u_sbpi_i2c_master_model.stop();
        cyc(2);
        chk({7'h00, alert_line}, 8'h00);
        read_frame(b);
        cyc(1);
        chk_alert(1'b1);
    endtask : test_alert_int

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        sel = 3'h0;
        cfg = '0;
        flags = '0;
        rd_data = 8'h96;
        miscompares = 0;
        total_checks = 0;
        wr_cnt = 0;
        rd_cnt = 0;
        test_reset();
        test_write();
        test_mismatch();
        test_read();
        test_alert_cmp();
        test_alert_int();
        cyc(2);
        conclude();
    end

    initial begin
        #200000;
        miscompares++;
        conclude();
    end
endmodule : testbench
